// *** hw/bar_width_capture.sv ***
// bar and space width capture with width FIFO for the host
// assumes SCAN_IN and host strobes are synchronous to CLK_SYS
//
// Notes on behaviour
// R01 - black and white areas are timed by two separate resettable 16-bit up counters.
// R02 - scanner transitions are found by registering the signal on the master clock and comparing.
// R03 - counters run on the master clock, here CLK_SYS, with no enable.
// R04 - a width word is written only after its area has ended, never while it is measured.
// R05 - FIFO address counters advance only per completed word, not per clock.
// R06 - at the end of a scan an FF hex end-of-label word is written into the FIFO.
// R07 - an interrupt is raised on end of label or end of scan, each selectable.
// R08 - the host reads raw black and white widths from the FIFO and normalizes them itself.
// R09 - on each transition the ended area's count is captured, its counter cleared, the other started; here captured only in ST_LABEL with FIFO room.
`timescale 1ns/100ps
`default_nettype none
module bar_width_capture
	import bar_width_pkg::*;
#(
	parameter int COUNT_BITS = COUNT_W,
	parameter int ADDR_BITS  = FIFO_AW,
	parameter int SCAN_GAP   = END_SCAN_CYC
) (
	input  wire logic                  CLK_SYS,
	input  wire logic                  RST_B,
	input  wire logic                  SCAN_IN,
	input  wire logic                  SCAN_DONE,
	input  wire logic                  IRQ_ON_LABEL,
	input  wire logic                  IRQ_ON_SCAN,
	input  wire logic                  RD_REQ,
	input  wire logic                  IRQ_ACK,
	output var  logic [COUNT_BITS-1:0] RD_DATA,
	output var  logic                  RD_VALID,
	output var  logic                  FIFO_EMPTY,
	output var  logic                  FIFO_FULL,
	output var  logic                  IRQ
);
	// ==========================================
	// edge detection
	logic       scan_q;
	logic       scan_prev;
	logic       edge_seen;

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			scan_q    <= 1'b0;
			scan_prev <= 1'b0;
		end else begin
			scan_q    <= SCAN_IN; // [R02]
			scan_prev <= scan_q;
		end
	end
	assign edge_seen = scan_q ^ scan_prev; // [R02]

	// ==========================================
	// area counters
	logic [COUNT_BITS-1:0] black_cnt;
	logic [COUNT_BITS-1:0] white_cnt;
	logic [COUNT_BITS-1:0] gap_cnt;
	logic                  scan_end;
	scan_state_t           state;
	logic                  fifo_full_int;

	// saturate rather than wrap, so an overlong area reads as maximum
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			black_cnt <= COUNT_ZERO;
			white_cnt <= COUNT_ZERO;
		end else if (edge_seen) begin
			black_cnt <= (scan_q == LEVEL_BLACK) ? COUNT_ONE : COUNT_ZERO; // [R09] [R01]
			white_cnt <= (scan_q == LEVEL_BLACK) ? COUNT_ZERO : COUNT_ONE; // [R09] [R01]
		end else if (scan_prev == LEVEL_BLACK) begin
			if (black_cnt != COUNT_MAX) black_cnt <= black_cnt + COUNT_ONE; // [R03]
		end else begin
			if (white_cnt != COUNT_MAX) white_cnt <= white_cnt + COUNT_ONE; // [R03]
		end
	end

	// quiet white time after a label also ends the scan
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			gap_cnt <= COUNT_ZERO;
		end else if (edge_seen || state != ST_LABEL) begin
			gap_cnt <= COUNT_ZERO;
		end else if (gap_cnt != COUNT_MAX) begin
			gap_cnt <= gap_cnt + COUNT_ONE;
		end
	end
	assign scan_end = SCAN_DONE || (gap_cnt == COUNT_BITS'(SCAN_GAP));

	// ==========================================
	// label sequencing
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (edge_seen && scan_q == LEVEL_BLACK) state <= ST_LABEL; // [R02]
				end
				ST_LABEL: begin
					if (scan_end) state <= ST_MARK; // [R07]
				end
				ST_MARK: begin
					if (!fifo_full_int) state <= ST_IDLE; // [R06]
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// FIFO write side
	logic [ADDR_BITS:0]    wr_ptr;
	logic [ADDR_BITS:0]    rd_ptr;
	logic                  wr_en;
	logic [COUNT_BITS-1:0] wr_word;
	logic                  fifo_empty_int;
	logic                  mark_write;

	assign fifo_full_int  = (wr_ptr[ADDR_BITS] != rd_ptr[ADDR_BITS]) &&
	                        (wr_ptr[ADDR_BITS-1:0] == rd_ptr[ADDR_BITS-1:0]);
	assign fifo_empty_int = (wr_ptr == rd_ptr);
	assign mark_write     = (state == ST_MARK) && !fifo_full_int; // [R06]

	// the first edge of a label opens the first bar; nothing has ended yet
	always_comb begin
		wr_en   = 1'b0;
		wr_word = COUNT_ZERO;
		if (mark_write) begin
			wr_en   = 1'b1;
			wr_word = END_MARK; // [R06]
		end else if (state == ST_LABEL && edge_seen && !fifo_full_int) begin
			wr_en   = 1'b1; // [R04]
			wr_word = (scan_prev == LEVEL_BLACK) ? black_cnt : white_cnt; // [R09]
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			wr_ptr <= '0;
		end else if (wr_en) begin
			wr_ptr <= wr_ptr + 1'b1; // [R05]
		end
	end

	// ==========================================
	// FIFO read side, host drains raw widths
	logic                  rd_take;
	logic [COUNT_BITS-1:0] mem_q;

	assign rd_take = RD_REQ && !fifo_empty_int; // [R08]

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rd_ptr <= '0;
		end else if (rd_take) begin
			rd_ptr <= rd_ptr + 1'b1; // [R05]
		end
	end

	width_fifo_mem #(
		.DATA_W (COUNT_BITS),
		.ADDR_W (ADDR_BITS)
	) u_mem (
		.clk     (CLK_SYS),
		.wr_en   (wr_en),
		.wr_addr (wr_ptr[ADDR_BITS-1:0]),
		.wr_data (wr_word),
		.rd_addr (rd_ptr[ADDR_BITS-1:0]),
		.rd_data (mem_q)
	);

	logic rd_pend;
	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			rd_pend  <= 1'b0;
			RD_VALID <= 1'b0;
			RD_DATA  <= COUNT_ZERO;
		end else begin
			rd_pend  <= rd_take;
			RD_VALID <= rd_pend;
			if (rd_pend) RD_DATA <= mem_q;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			FIFO_EMPTY <= 1'b1;
			FIFO_FULL  <= 1'b0;
		end else begin
			FIFO_EMPTY <= fifo_empty_int;
			FIFO_FULL  <= fifo_full_int;
		end
	end

	// ==========================================
	// interrupt, new event wins over acknowledge
	logic irq_event;
	assign irq_event = (mark_write && IRQ_ON_LABEL) ||
	                   (state == ST_LABEL && scan_end && IRQ_ON_SCAN); // [R07]

	always_ff @(posedge CLK_SYS or negedge RST_B) begin
		if (!RST_B) begin
			IRQ <= 1'b0;
		end else if (irq_event) begin
			IRQ <= 1'b1; // [R07]
		end else if (IRQ_ACK) begin
			IRQ <= 1'b0;
		end
	end

	// ==========================================
	// checks
	a_mark_written: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		mark_write |-> wr_word == END_MARK ##1 (state == ST_IDLE && wr_ptr == $past(wr_ptr) + 1'b1)) // [R06]
		else $error("end mark not written");
	a_no_write_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state == ST_IDLE) |-> !wr_en) // [R04]
		else $error("write outside label");
	a_ptr_step: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!wr_en |=> $stable(wr_ptr)) // [R05]
		else $error("write pointer moved without word");
	a_count_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		edge_seen |=> (black_cnt == COUNT_ZERO) != (white_cnt == COUNT_ZERO)) // [R09]
		else $error("counter not restarted on edge");
	a_black_runs: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(!edge_seen && scan_prev == LEVEL_BLACK && black_cnt < COUNT_MAX) |=>
		black_cnt == $past(black_cnt) + COUNT_ONE) // [R01]
		else $error("black counter stalled");
	a_white_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(!edge_seen && scan_prev == LEVEL_BLACK) |=> $stable(white_cnt)) // [R03]
		else $error("white counter ran in black area");
	a_edge_seen: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(scan_q != $past(scan_q)) |-> edge_seen) // [R02]
		else $error("edge missed");
	a_irq_label: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(mark_write && IRQ_ON_LABEL) |=> IRQ) // [R07]
		else $error("label interrupt missing");
	a_read_valid: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		rd_take |-> ##2 RD_VALID) // [R08]
		else $error("read data late");

	c_label: cover property (@(posedge CLK_SYS) disable iff (!RST_B) mark_write);
	c_width: cover property (@(posedge CLK_SYS) disable iff (!RST_B) wr_en && !mark_write);
	c_full:  cover property (@(posedge CLK_SYS) disable iff (!RST_B) fifo_full_int);
	c_irq:   cover property (@(posedge CLK_SYS) disable iff (!RST_B) IRQ && IRQ_ACK);
endmodule : bar_width_capture
`default_nettype wire

// *** hw/bar_width_pkg.sv ***
// constants and types shared by the bar width capture block
// assumes a single 25 MHz system clock and a synchronous scanner input
package bar_width_pkg;
	localparam int          COUNT_W       = 16;
	localparam int          FIFO_AW       = 8;
	localparam logic [15:0] END_MARK      = 16'h00FF;
	localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE     = 16'h0001;
	localparam logic [15:0] COUNT_ZERO    = 16'h0000;
	localparam int          CLK_HZ        = 25000000;
	localparam int          END_SCAN_NS   = 100000;
	localparam int          END_SCAN_CYC  = (END_SCAN_NS / 1000) * (CLK_HZ / 1000000);
	localparam logic        LEVEL_BLACK   = 1'b1;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LABEL = 2'b01,
		ST_MARK  = 2'b11
	} scan_state_t;
endpackage : bar_width_pkg

// *** hw/width_fifo_mem.sv ***
// word memory holding captured widths until the host drains them
// assumes one writer and one reader in the same clock domain
`timescale 1ns/100ps
`default_nettype none
module width_fifo_mem #(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output var  logic [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule : width_fifo_mem
`default_nettype wire

// *** verif/bar_width_capture_bench.sv ***
// bench for the bar width capture block
// assumes the scanner model drives SCAN_IN and SCAN_DONE
`timescale 1ns/100ps
`default_nettype none
module bar_width_capture_bench;
	import bar_width_pkg::*;
	typedef struct {int a; int b; int c; logic lab; logic scn; logic irq;} row_t;
	logic        clk_sys, rst_b, scan_in, scan_done, on_lab, on_scn, rd_req, irq_ack;
	logic [15:0] rd_data;
	logic        rd_valid, fifo_empty, fifo_full, irq;
	int          err_count = 0;
	int          checked = 0;
	row_t        rows[4] = '{'{5,7,3,0,0,0}, '{1,1,1,1,0,1}, '{2,9,4,0,1,1}, '{16,3,8,1,1,1}};
	scan_model scan_model_i (.clk(clk_sys), .scan(scan_in), .done(scan_done));
	// four-word FIFO, so one label with its end mark fills it
	bar_width_capture #(.ADDR_BITS(2), .SCAN_GAP(20)) bar_width_capture_i (
		.CLK_SYS(clk_sys), .RST_B(rst_b), .SCAN_IN(scan_in), .SCAN_DONE(scan_done),
		.IRQ_ON_LABEL(on_lab), .IRQ_ON_SCAN(on_scn), .RD_REQ(rd_req), .IRQ_ACK(irq_ack),
		.RD_DATA(rd_data), .RD_VALID(rd_valid), .FIFO_EMPTY(fifo_empty),
		.FIFO_FULL(fifo_full), .IRQ(irq));
	// ====================
	task automatic end_of_test;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp16
	task automatic cmp1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp1
	// host pop; bounded wait for the valid pulse
	task automatic pop(input logic [15:0] exp);
		int n;
		rd_req = 1'b1;
		@(negedge clk_sys);
		rd_req = 1'b0;
		n = 0;
		while (rd_valid !== 1'b1 && n < 6) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 6) begin
			err_count++;
			end_of_test();
		end
		cmp16(rd_data, exp);
	endtask : pop
	// ====================
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		rst_b = 1'b0;
		rd_req = 1'b0;
		irq_ack = 1'b0;
		on_lab = 1'b0;
		on_scn = 1'b0;
		repeat (5) @(negedge clk_sys);
		cmp1(fifo_empty, 1'b1);
		cmp1(irq, 1'b0);
		rst_b = 1'b1;
		foreach (rows[i]) begin
			on_lab = rows[i].lab;
			on_scn = rows[i].scn;
			scan_model_i.play(rows[i].a, rows[i].b, rows[i].c, 1'b1);
			repeat (3) @(negedge clk_sys);
			cmp1(irq, rows[i].irq);
			pop(rows[i].a[15:0]);
			pop(rows[i].b[15:0]);
			pop(rows[i].c[15:0]);
			pop(END_MARK);
			cmp1(fifo_empty, 1'b1);
			irq_ack = 1'b1;
			@(negedge clk_sys);
			irq_ack = 1'b0;
			@(negedge clk_sys);
			cmp1(irq, 1'b0);
		end
		// pop while empty gives no word
		rd_req = 1'b1;
		@(negedge clk_sys);
		rd_req = 1'b0;
		repeat (3) begin
			@(negedge clk_sys);
			cmp1(rd_valid, 1'b0);
		end
		// quiet timer ends the scan
		on_lab = 1'b0;
		on_scn = 1'b1;
		scan_model_i.play(4, 2, 3, 1'b0);
		repeat (30) @(negedge clk_sys);
		cmp1(irq, 1'b1);
		pop(16'h0004);
		pop(16'h0002);
		pop(16'h0003);
		pop(END_MARK);
		cmp1(fifo_full, 1'b0);
		// reset in mid-run drops stored words
		scan_model_i.play(3, 3, 3, 1'b1);
		repeat (3) @(negedge clk_sys);
		cmp1(fifo_empty, 1'b0);
		cmp1(fifo_full, 1'b1);
		rst_b = 1'b0;
		@(negedge clk_sys);
		cmp1(fifo_empty, 1'b1);
		cmp1(irq, 1'b0);
		rst_b = 1'b1;
		repeat (2) begin
			@(negedge clk_sys);
			cmp1(fifo_empty, 1'b1);
			cmp1(rd_valid, 1'b0);
		end
		// labels are captured again after the mid-run reset
		scan_model_i.play(2, 5, 2, 1'b1);
		repeat (3) @(negedge clk_sys);
		cmp1(irq, 1'b1);
		pop(16'h0002);
		pop(16'h0005);
		pop(16'h0002);
		pop(END_MARK);
		end_of_test();
	end
endmodule : bar_width_capture_bench
`default_nettype wire

// *** verif/scan_model.sv ***
// scanner model: plays black and white areas on the scan line
// assumes play is called at a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module scan_model (
	input  wire logic clk,
	output var  logic scan,
	output var  logic done
);
	initial begin
		scan = 1'b0;
		done = 1'b0;
	end
	// ====================
	// one label: black a, white b, black c, then white rest
	task automatic play(input int a, input int b, input int c, input logic fin);
		scan = 1'b1;
		repeat (a) @(negedge clk);
		scan = 1'b0;
		repeat (b) @(negedge clk);
		scan = 1'b1;
		repeat (c) @(negedge clk);
		scan = 1'b0;
		repeat (3) @(negedge clk);
		// without fin the quiet timer must end the scan
		done = fin;
		@(negedge clk);
		done = 1'b0;
	endtask : play
endmodule : scan_model
`default_nettype wire
